// ==== tss_defines.svh ====
// Constants for the TV sound status read-back bank
`ifndef TSS_DEFINES_SVH
`define TSS_DEFINES_SVH

// ****************************************
// Subaddresses
// ****************************************
`define TSS_SUB_DEV_STATUS 8'h00
`define TSS_SUB_DIG_STATUS 8'h01
`define TSS_SUB_ERR_COUNT 8'h02
`define TSS_SUB_ID_FIRST 8'hfc
`define TSS_SUB_ID_SECOND 8'hfd
`define TSS_SUB_ID_THIRD 8'hfe
`define TSS_SUB_ID_FOURTH 8'hff
`define TSS_UNMAPPED_DATA 8'hff

// ****************************************
// Device status field positions
// ****************************************
`define TSS_DS_PIN_TWO 7
`define TSS_DS_PIN_ONE 6
`define TSS_DS_RESERVE 5
`define TSS_DS_AUTO_MUTE 4
`define TSS_DS_PRESENT 3
`define TSS_DS_DUAL 2
`define TSS_DS_STEREO 1
`define TSS_DS_SUPPLY_DIP 0

// ****************************************
// Digital sound status field positions
// ****************************************
`define TSS_NS_APP_HI 7
`define TSS_NS_APP_LO 4
`define TSS_NS_SYNC 3
`define TSS_NS_CFG 2
`define TSS_NS_STEREO 1
`define TSS_NS_DUAL 0

// ****************************************
// Reset values and bus constants
// ****************************************
`define TSS_RST_BYTE 8'h00
`define TSS_RST_ADDR 8'h00
`define TSS_BITS_PER_BYTE 4'h8
`define TSS_SLAVE_ADDR 7'h5a

// ****************************************
// Timing
// ****************************************
`define TSS_ERR_WINDOW_MS 128
`define TSS_CLK_KHZ 125000
`define TSS_ERR_WINDOW_CYCLES (`TSS_ERR_WINDOW_MS * `TSS_CLK_KHZ)

`endif

// ==== tss_pkg.sv ====
// Types for the TV sound status read-back bank
package tss_pkg;

  // ****************************************
  // Status from the demodulator and decoder
  // ****************************************
  typedef struct packed {
    logic app_control_bit_four;
    logic app_control_bit_three;
    logic app_control_bit_two;
    logic app_control_bit_one;
    logic sync_locked;
    logic config_changed;
    logic digital_stereo_mode;
    logic digital_dual_mono_mode;
    logic digital_sound_present;
    logic analog_dual_identified;
    logic analog_stereo_identified;
    logic mute_request;
  } tss_demod_s;

  // ****************************************
  // Serial slave states and byte kinds
  // ****************************************
  typedef enum logic [2:0] {
    TSS_IDLE,
    TSS_RECV,
    TSS_ACK,
    TSS_SEND,
    TSS_MACK
  } tss_state_e;

  typedef enum logic [1:0] {
    TSS_K_ADDR,
    TSS_K_SUB,
    TSS_K_WDATA
  } tss_kind_e;

endpackage : tss_pkg

// ==== tss_err_window.sv ====
// Windowed error counter that reloads its result once per window
`timescale 1ns/1ps
`include "tss_defines.svh"
module tss_err_window #(
  parameter int WINDOW_CYCLES = `TSS_ERR_WINDOW_CYCLES,
  parameter int CNT_W = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic error_pulse,
  output logic [CNT_W-1:0] count_ff
);

  import tss_pkg::*;

  localparam int TW = $clog2(WINDOW_CYCLES + 1);
  localparam logic [TW-1:0] TLAST = TW'(WINDOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] CMAX = {CNT_W{1'b1}};

  logic [TW-1:0] timer_ff;
  logic [CNT_W-1:0] acc_ff;
  logic win_end;

  assign win_end = (timer_ff == TLAST);

  // ****************************************
  // Window timer
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timer_ff <= '0;
    end else if (win_end) begin
      timer_ff <= '0;
    end else begin
      timer_ff <= timer_ff + TW'(1);
    end
  end

  // ****************************************
  // Accumulator, saturating; an error in the last cycle belongs to the closing window
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc_ff <= '0;
    end else if (win_end) begin
      acc_ff <= '0;
    end else if (error_pulse && acc_ff != CMAX) begin
      acc_ff <= acc_ff + CNT_W'(1);
    end
  end

  // ****************************************
  // Result of the previous window
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_ff <= '0;
    end else if (win_end) begin
      count_ff <= (error_pulse && acc_ff != CMAX) ? acc_ff + CNT_W'(1) : acc_ff;
    end
  end

endmodule : tss_err_window

// ==== tss_status_bank.sv ====
// Read-only status bank of a TV sound decoder behind a serial slave port
//
// Overview of operation
// - device status bit 7 returns the live level of port pin two.
// - device status bit 6 returns the live level of port pin one.
// - device status bit 5 mirrors application control bit four.
// - device status bit 4 is 1 while auto-mute selects first carrier.
// - device status bit 3 is 1 when the digital stream carries sound.
// - device status bit 2 is 1 once analog dual language is identified.
// - device status bit 1 is 1 once analog stereo is identified.
// - device status bit 0 is set after a digital supply dip.
// - digital status bits 7..4 carry application control bits four..one.
// - digital status bit 3 is 1 only with frame and multiframe sync.
// - without sync the digital decoder outputs silence.
// - digital status bit 2 reports a configuration change at multiframe boundary.
// - digital status bit 1 is stereo mode, bit 0 dual-mono mode.
// - control bit three set forces first carrier reproduction regardless of enable.
// - lost sync forces first carrier reproduction regardless of enable.
// - error count holds errors of the previous 128 ms, reloaded every window.
// - subaddresses 252..255 are read-only identification registers.
// - the pointer advances by one after every transmitted byte.
// - the pointer wraps from 255 to 0.
// - unimplemented subaddresses read as all ones.
`timescale 1ns/1ps
`include "tss_defines.svh"
module tss_status_bank #(
  parameter logic [6:0] SLAVE_ADDR = `TSS_SLAVE_ADDR,
  parameter int ERR_WINDOW_CYCLES = `TSS_ERR_WINDOW_CYCLES,
  // Identification bytes; values are arbitrary
  parameter logic [7:0] ID_BYTE_0 = 8'h3c,
  parameter logic [7:0] ID_BYTE_1 = 8'h02,
  parameter logic [7:0] ID_BYTE_2 = 8'h5e,
  parameter logic [7:0] ID_BYTE_3 = 8'h01
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic port_pin_one,
  input wire logic port_pin_two,
  input wire logic supply_dip,
  input wire logic error_pulse,
  input wire logic auto_mute_enable,
  input wire tss_pkg::tss_demod_s demod,
  output logic digital_silence,
  output logic first_carrier_select
);

  import tss_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic scl_m_ff, scl_s_ff, scl_d_ff;
  logic sda_m_ff, sda_s_ff, sda_d_ff;
  logic pin1_m_ff, pin1_s_ff;
  logic pin2_m_ff, pin2_s_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= sda_in;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin1_m_ff <= 1'b0;
      pin1_s_ff <= 1'b0;
      pin2_m_ff <= 1'b0;
      pin2_s_ff <= 1'b0;
    end else begin
      pin1_m_ff <= port_pin_one;
      pin1_s_ff <= pin1_m_ff;
      pin2_m_ff <= port_pin_two;
      pin2_s_ff <= pin2_m_ff;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;

  assign scl_rise = scl_s_ff && !scl_d_ff;
  assign scl_fall = !scl_s_ff && scl_d_ff;
  assign bus_start = scl_s_ff && scl_d_ff && !sda_s_ff && sda_d_ff;
  assign bus_stop = scl_s_ff && scl_d_ff && sda_s_ff && !sda_d_ff;

  // ****************************************
  // Reproduction selection and silence
  // ****************************************
  logic auto_mute_active_ff;
  logic digital_silence_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      auto_mute_active_ff <= 1'b1;
    end else begin
      auto_mute_active_ff <= !demod.sync_locked
        || demod.app_control_bit_three
        || (auto_mute_enable && demod.mute_request);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      digital_silence_ff <= 1'b1;
    end else begin
      digital_silence_ff <= !demod.sync_locked;
    end
  end

  assign digital_silence = digital_silence_ff;
  assign first_carrier_select = auto_mute_active_ff;

  // ****************************************
  // Error count over the window
  // ****************************************
  logic [7:0] err_count;

  tss_err_window #(
    .WINDOW_CYCLES(ERR_WINDOW_CYCLES),
    .CNT_W(8)
  ) u_err_window (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .error_pulse(error_pulse),
    .count_ff(err_count)
  );

  // ****************************************
  // Register read multiplexer
  // ****************************************
  logic supply_dip_flag_ff;
  logic [7:0] dev_status, dig_status, rd_byte;
  logic [7:0] ptr_ff;

  always_comb begin
    dev_status = `TSS_RST_BYTE;
    dev_status[`TSS_DS_PIN_TWO] = pin2_s_ff;
    dev_status[`TSS_DS_PIN_ONE] = pin1_s_ff;
    dev_status[`TSS_DS_RESERVE] = demod.app_control_bit_four;
    dev_status[`TSS_DS_AUTO_MUTE] = auto_mute_active_ff;
    dev_status[`TSS_DS_PRESENT] = demod.digital_sound_present;
    dev_status[`TSS_DS_DUAL] = demod.analog_dual_identified;
    dev_status[`TSS_DS_STEREO] = demod.analog_stereo_identified;
    dev_status[`TSS_DS_SUPPLY_DIP] = supply_dip_flag_ff;
  end

  always_comb begin
    dig_status = `TSS_RST_BYTE;
    dig_status[`TSS_NS_APP_HI:`TSS_NS_APP_LO] = {demod.app_control_bit_four,
      demod.app_control_bit_three, demod.app_control_bit_two,
      demod.app_control_bit_one};
    dig_status[`TSS_NS_SYNC] = demod.sync_locked;
    dig_status[`TSS_NS_CFG] = demod.config_changed;
    dig_status[`TSS_NS_STEREO] = demod.digital_stereo_mode;
    dig_status[`TSS_NS_DUAL] = demod.digital_dual_mono_mode;
  end

  always_comb begin
    case (ptr_ff)
      `TSS_SUB_DEV_STATUS: rd_byte = dev_status;
      `TSS_SUB_DIG_STATUS: rd_byte = dig_status;
      `TSS_SUB_ERR_COUNT: rd_byte = err_count;
      `TSS_SUB_ID_FIRST: rd_byte = ID_BYTE_0;
      `TSS_SUB_ID_SECOND: rd_byte = ID_BYTE_1;
      `TSS_SUB_ID_THIRD: rd_byte = ID_BYTE_2;
      `TSS_SUB_ID_FOURTH: rd_byte = ID_BYTE_3;
      default: rd_byte = `TSS_UNMAPPED_DATA;
    endcase
  end

  // ****************************************
  // Serial slave state machine
  // ****************************************
  tss_state_e state_ff;
  tss_kind_e kind_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic read_dir_ff;
  logic sda_oe_n_ff;
  logic load_tx;

  // A byte is loaded for sending on the falling clock after the read address
  // acknowledge, or after a master acknowledge
  assign load_tx = scl_fall && ((state_ff == TSS_ACK && kind_ff == TSS_K_ADDR && read_dir_ff)
    || state_ff == TSS_MACK);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= TSS_IDLE;
      kind_ff <= TSS_K_ADDR;
      bit_cnt_ff <= 4'h0;
      shift_ff <= `TSS_RST_BYTE;
      read_dir_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end else if (bus_stop) begin
      state_ff <= TSS_IDLE;
      sda_oe_n_ff <= 1'b1;
    end else if (bus_start) begin
      state_ff <= TSS_RECV;
      kind_ff <= TSS_K_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_oe_n_ff <= 1'b1;
    end else begin
      case (state_ff)
        TSS_IDLE: begin
          sda_oe_n_ff <= 1'b1;
        end
        TSS_RECV: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_s_ff};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == `TSS_BITS_PER_BYTE) begin
            bit_cnt_ff <= 4'h0;
            if (kind_ff != TSS_K_ADDR || shift_ff[7:1] == SLAVE_ADDR) begin
              // Written data bytes are acknowledged and dropped
              state_ff <= TSS_ACK;
              sda_oe_n_ff <= 1'b0;
              if (kind_ff == TSS_K_ADDR) begin
                read_dir_ff <= shift_ff[0];
              end
            end else begin
              state_ff <= TSS_IDLE;
            end
          end
        end
        TSS_ACK: begin
          if (load_tx) begin
            shift_ff <= rd_byte;
            sda_oe_n_ff <= rd_byte[7];
            state_ff <= TSS_SEND;
          end else if (scl_fall) begin
            sda_oe_n_ff <= 1'b1;
            state_ff <= TSS_RECV;
            kind_ff <= (kind_ff == TSS_K_ADDR) ? TSS_K_SUB : TSS_K_WDATA;
          end
        end
        TSS_SEND: begin
          if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_ff == `TSS_BITS_PER_BYTE) begin
              bit_cnt_ff <= 4'h0;
              sda_oe_n_ff <= 1'b1;
              state_ff <= TSS_MACK;
            end else begin
              shift_ff <= {shift_ff[6:0], 1'b1};
              sda_oe_n_ff <= shift_ff[6];
            end
          end
        end
        TSS_MACK: begin
          if (scl_rise && sda_s_ff) begin
            // Master did not acknowledge: stop sending until the next start
            state_ff <= TSS_IDLE;
          end else if (load_tx) begin
            shift_ff <= rd_byte;
            sda_oe_n_ff <= rd_byte[7];
            state_ff <= TSS_SEND;
          end
        end
        default: begin
          state_ff <= TSS_IDLE;
          sda_oe_n_ff <= 1'b1;
        end
      endcase
    end
  end

  assign sda_oe_n = sda_oe_n_ff;
  assign sda_out = 1'b0;

  // ****************************************
  // Register pointer
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ptr_ff <= `TSS_RST_ADDR;
    end else if (!bus_stop && !bus_start && state_ff == TSS_RECV && kind_ff == TSS_K_SUB
                 && scl_fall && bit_cnt_ff == `TSS_BITS_PER_BYTE) begin
      ptr_ff <= shift_ff;
    end else if (!bus_stop && !bus_start && state_ff == TSS_SEND && scl_fall
                 && bit_cnt_ff == `TSS_BITS_PER_BYTE) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  // ****************************************
  // Supply dip flag: sticky, cleared when read, a new dip wins
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      supply_dip_flag_ff <= 1'b1;
    end else if (supply_dip) begin
      supply_dip_flag_ff <= 1'b1;
    end else if (load_tx && !bus_stop && !bus_start && ptr_ff == `TSS_SUB_DEV_STATUS) begin
      supply_dip_flag_ff <= 1'b0;
    end
  end

endmodule : tss_status_bank

// ==== tss_status_bank_properties.sv ====
// Port-level checks for the status bank
`timescale 1ns/1ps
module tss_status_bank_properties (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_oe_n,
  input wire logic auto_mute_enable,
  input wire tss_pkg::tss_demod_s demod,
  input wire logic digital_silence,
  input wire logic first_carrier_select
);
  import tss_pkg::*;
  logic keep;
  logic am;
  assign keep = demod.sync_locked && !demod.app_control_bit_three;
  assign am = auto_mute_enable && demod.mute_request;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // ****
  // Reproduction select and silence
  // ****
  silence_track_a: assert property (
    $past(nrst) |-> digital_silence == !$past(demod.sync_locked))
    else $error("silence does not follow lock");
  sync_lost_a: assert property (
    $fell(demod.sync_locked) |=> first_carrier_select && digital_silence)
    else $error("lock loss not forcing first carrier");
  c3_forces_a: assert property (
    $past(nrst) && $past(demod.app_control_bit_three) |-> first_carrier_select)
    else $error("control bit three not forcing first carrier");
  auto_mute_a: assert property (
    am |=> first_carrier_select)
    else $error("auto mute not selecting first carrier");
  carrier_off_a: assert property (
    $past(nrst) && $past(keep && !am) |-> !first_carrier_select)
    else $error("first carrier selected without cause");
  carrier_cause_a: assert property (
    $past(nrst) && !first_carrier_select |-> $past(keep))
    else $error("digital sound kept while forced");
  // ****
  // Serial data pin
  // ****
  oe_high_a: assert property (
    scl [*2] |-> $stable(sda_oe_n))
    else $error("data pin changed while clock high");
  oe_late_a: assert property (
    $fell(scl) |=> $stable(sda_oe_n) [*2])
    else $error("data pin changed too soon after clock fall");
  ack_seen_c: cover property ($fell(sda_oe_n));
  forced_c: cover property (demod.app_control_bit_three ##1 first_carrier_select);
  lost_sync_c: cover property ($fell(demod.sync_locked));
endmodule : tss_status_bank_properties

bind tss_status_bank tss_status_bank_properties u_props (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .scl(scl),
  .sda_oe_n(sda_oe_n),
  .auto_mute_enable(auto_mute_enable),
  .demod(demod),
  .digital_silence(digital_silence),
  .first_carrier_select(first_carrier_select)
);

// ==== tss_host_model.sv ====
// Serial bus master model that reads and writes the status bank
`timescale 1ns/1ps
`include "tss_defines.svh"
module tss_host_model (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  // ****
  // Bus phases
  // ****
  // Half bit of 16 cycles keeps each clock phase above the minimum
  task automatic half();
    repeat (16) @(negedge ref_clk);
  endtask : half
  task automatic bit_io(input logic b, output logic s);
    sda = b;
    half();
    scl = 1'b1;
    half();
    s = sda_line;
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    sda = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda = 1'b1;
    half();
  endtask : stop
  task automatic put(input logic [7:0] b, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ok &= !s;
  endtask : put
  // Subaddress first, repeated start, last byte left unacked
  task automatic rd(input logic [7:0] sub, input int n, output logic [31:0] d,
                    output logic ok);
    logic [7:0] b;
    logic s;
    ok = 1'b1;
    d = 32'h0;
    start();
    put({`TSS_SLAVE_ADDR, 1'b0}, ok);
    put(sub, ok);
    start();
    put({`TSS_SLAVE_ADDR, 1'b1}, ok);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(1'b1, s);
        b[i] = s;
      end
      bit_io(k == n - 1, s);
      d = {d[23:0], b};
    end
    stop();
  endtask : rd
  task automatic wr(input logic [7:0] sub, input logic [7:0] v, output logic ok);
    ok = 1'b1;
    start();
    put({`TSS_SLAVE_ADDR, 1'b0}, ok);
    put(sub, ok);
    put(v, ok);
    stop();
  endtask : wr
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
endmodule : tss_host_model

// ==== tb_tss_status_bank.sv ====
// Self-checking bench for the status bank
`timescale 1ns/1ps
`include "tss_defines.svh"
module tb_tss_status_bank;
  import tss_pkg::*;
  // Identification bytes; values are arbitrary
  localparam logic [7:0] ID_A = 8'h9b;
  localparam logic [7:0] ID_B = 8'h4e;
  localparam logic [7:0] ID_C = 8'h71;
  localparam logic [7:0] ID_D = 8'hc2;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic port_pin_one = 1'b0;
  logic port_pin_two = 1'b0;
  logic supply_dip = 1'b0;
  logic error_pulse = 1'b0;
  logic auto_mute_enable = 1'b0;
  tss_demod_s demod = 12'h000;
  logic sda_out;
  logic sda_oe_n;
  logic digital_silence;
  logic first_carrier_select;
  logic scl;
  logic host_sda;
  logic sda_line;
  logic dip_exp = 1'b1;
  logic ok;
  logic [31:0] d;
  int miscompares = 0;
  int checked = 0;
  // Open-drain data wire with pull-up
  assign sda_line = host_sda & (sda_oe_n | sda_out);
  always #4 ref_clk = ~ref_clk;
  tss_status_bank #(.ERR_WINDOW_CYCLES(300), .ID_BYTE_0(ID_A), .ID_BYTE_1(ID_B),
    .ID_BYTE_2(ID_C), .ID_BYTE_3(ID_D)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .port_pin_one(port_pin_one),
    .port_pin_two(port_pin_two), .supply_dip(supply_dip), .error_pulse(error_pulse),
    .auto_mute_enable(auto_mute_enable), .demod(demod),
    .digital_silence(digital_silence), .first_carrier_select(first_carrier_select)
  );
  tss_host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda(host_sda));
  // ****
  // Compare and helpers
  // ****
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte
  task automatic check_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  function automatic logic fcs_exp();
    return !demod.sync_locked | demod.app_control_bit_three |
      (auto_mute_enable & demod.mute_request);
  endfunction : fcs_exp
  function automatic logic [7:0] dev_exp();
    return {port_pin_two, port_pin_one, demod.app_control_bit_four, fcs_exp(),
      demod.digital_sound_present, demod.analog_dual_identified,
      demod.analog_stereo_identified, dip_exp};
  endfunction : dev_exp
  task automatic apply(input logic p2, input logic p1, input logic am, input logic [11:0] v);
    @(negedge ref_clk);
    port_pin_two = p2;
    port_pin_one = p1;
    auto_mute_enable = am;
    demod = v;
    repeat (4) @(negedge ref_clk);
  endtask : apply
  task automatic end_sim();
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // ****
  // Scenarios
  // ****
  // Two patterns with opposite pins and auto-mute enable, each read as one three-byte burst
  task automatic t_status();
    for (int p = 0; p < 2; p++) begin
      apply(p == 0, p == 1, p == 0, p == 0 ? 12'haab : 12'h1d5);
      if (p == 1) begin
        supply_dip = 1'b1;
        @(negedge ref_clk);
        supply_dip = 1'b0;
        dip_exp = 1'b1;
      end
      check_bit("carrier", fcs_exp(), first_carrier_select);
      host.rd(`TSS_SUB_DEV_STATUS, 3, d, ok);
      check_bit("ack", 1'b1, ok);
      check_byte("dev", dev_exp(), d[23:16]);
      check_byte("dig", demod[11:4], d[15:8]);
      check_byte("err", 8'h00, d[7:0]);
      dip_exp = 1'b0;
    end
  endtask : t_status
  // Lock loss, control bit three, auto mute on and off
  task automatic t_force();
    for (int i = 0; i < 4; i++) begin
      apply(1'b0, 1'b0, i == 2, i == 0 ? 12'h000 : (i == 1 ? 12'h480 : 12'h081));
      check_bit("carrier", fcs_exp(), first_carrier_select);
      check_bit("silence", !demod.sync_locked, digital_silence);
    end
  endtask : t_force
  // Errors every cycle saturate the count, then a quiet window clears it
  task automatic t_errors();
    error_pulse = 1'b1;
    repeat (700) @(negedge ref_clk);
    host.rd(`TSS_SUB_ERR_COUNT, 1, d, ok);
    check_byte("err full", 8'hff, d[7:0]);
    error_pulse = 1'b0;
    repeat (700) @(negedge ref_clk);
    host.rd(`TSS_SUB_ERR_COUNT, 1, d, ok);
    check_byte("err none", 8'h00, d[7:0]);
  endtask : t_errors
  // Ignored writes, identification bytes, wrap and unmapped place
  task automatic t_map();
    host.wr(`TSS_SUB_DIG_STATUS, ~demod[11:4], ok);
    check_bit("wr ack", 1'b1, ok);
    host.wr(`TSS_SUB_ID_FIRST, ~ID_A, ok);
    host.rd(`TSS_SUB_ID_FIRST, 2, d, ok);
    check_byte("id first", ID_A, d[15:8]);
    check_byte("id second", ID_B, d[7:0]);
    host.rd(`TSS_SUB_ID_THIRD, 4, d, ok);
    check_byte("id third", ID_C, d[31:24]);
    check_byte("id fourth", ID_D, d[23:16]);
    check_byte("wrap dev", dev_exp(), d[15:8]);
    check_byte("wrap dig", demod[11:4], d[7:0]);
    host.rd(8'h05, 1, d, ok);
    check_byte("unmapped", `TSS_UNMAPPED_DATA, d[7:0]);
  endtask : t_map
  initial begin
    repeat (2) @(negedge ref_clk);
    check_bit("rst silence", 1'b1, digital_silence);
    check_bit("rst oe", 1'b1, sda_oe_n);
    check_bit("rst sda out", 1'b0, sda_out);
    nrst = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_status();
    t_force();
    t_errors();
    t_map();
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    end_sim();
  end
endmodule : tb_tss_status_bank
